// >>> mrd_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Target bit clear sends enabled sub-region accesses to ISA cycles.
// - Target bit set means local bus device; deselect on CPU access.
// - Local region hit by DMA or master: we run local bus cycle.
// - Size bit 5 clear: compare A23-A19, 512 KB below 16 MB.
// - Size bits 10: compare A26-A23, 8 MB below 128 MB.
// - Size bits 11: compare A17-A14, 16 KB in C0000h-FFFFFh.
// - Region splits in eight slices; enable bit 0 is lowest slice.
// - Slice is 1 MB, 64 KB or 2 KB by region size.
// - Set enable applies region mapping; clear keeps defaults; any mix.
// - Programmed regions override default and segment settings.
// - Overlap with segment cacheability: non-cacheable wins.
// - ISA regions above 16 MB alias to 24-bit; no DMA there.
// - Unclaimed accesses below 16 MB go to ISA.
// - Steer data for 8-32 bit CPU to 8/16 bit ISA; no parity.
// - A31 and A29 set reach full ISA space, non-cacheable.
// - ISA areas uncached by default; enabled region may make cacheable.
// - Unremapped CPU accesses F0000h-FFFFFh are system ROM.
// - ROM chip select low on every system ROM access.
// - ROM wait field adds extra ISA wait states to ROM.
// - 8-bit ROM from SA0 on D23-D16 when on D bus; 16-bit from SA1 on D31-D16.
// - Width and bus straps sampled at power-up.
// - Relocation bits 5,4 make C and E ranges system ROM.
// - Relocation bit 6 puts all ROM on D bus or SD bus.
// - Index port ECh then data port EDh reach the registers.
module mrd_decoder
    import mrd_pkg::*;
(
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic                 IO_WR,
    input  wire logic                 IO_RD,
    input  wire logic [7:0]           IO_ADDR,
    input  wire logic [7:0]           IO_WDATA,
    output logic      [7:0]           IO_RDATA,
    input  wire logic                 ROM_WIDTH_STRAP,
    input  wire logic                 ROM_BUS_STRAP,
    input  wire logic                 MEM_REQ,
    input  wire logic                 MEM_IS_CPU,
    input  wire logic [31:0]          MEM_ADDR,
    input  wire logic                 DRAM_CLAIM,
    input  wire logic                 SHADOW_CLAIM,
    input  wire logic                 SEG_REMAP,
    input  wire logic                 SEG_UNCACHED,
    input  wire logic                 LOCAL_DEV_CLAIM,
    output mrd_pkg::mrd_target_e      TARGET,
    output logic                      CACHEABLE,
    output logic                      DESELECT,
    output logic                      LOCAL_CYCLE,
    output logic                      ROM_CHIP_SELECT_N,
    output logic                      ROM_ON_SD_BUS,
    output logic                      ROM_16BIT,
    output logic      [1:0]           ROM_EXTRA_WAITS,
    output logic      [23:0]          ISA_ADDR,
    output logic                      ISA_ADDR_FROM_SA1,
    output logic                      DATA_ON_D23_16,
    output logic                      PARITY_CHECK_EN
);
    import mrd_pkg::*;

    logic [7:0]  index_reg;
    logic [7:0]  r1_base_reg;
    logic [7:0]  r1_en_reg;
    logic [7:0]  r2_base_reg;
    logic [7:0]  r2_en_reg;
    logic [7:0]  rom_config_reg;
    logic        strap_done_reg;
    logic        hit1;
    logic        hit2;
    logic [1:0]  rom_waits;
    logic        data_rd;
    logic        data_wr;

    assign data_rd = IO_RD && (IO_ADDR == DATA_PORT);
    assign data_wr = IO_WR && (IO_ADDR == DATA_PORT);

    // Index latch
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            index_reg <= REG_RESET;
        end else if (IO_WR && IO_ADDR == IDX_PORT) begin
            index_reg <= IO_WDATA;
        end
    end

    // One register per index; unmapped indices are ignored
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r1_base_reg <= REG_RESET;
        end else if (data_wr && index_reg == IDX_R1_BASE) begin
            r1_base_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r1_en_reg <= REG_RESET;
        end else if (data_wr && index_reg == IDX_R1_EN) begin
            r1_en_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r2_base_reg <= REG_RESET;
        end else if (data_wr && index_reg == IDX_R2_BASE) begin
            r2_base_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r2_en_reg <= REG_RESET;
        end else if (data_wr && index_reg == IDX_R2_EN) begin
            r2_en_reg <= IO_WDATA;
        end
    end

    // Straps can't be taken under async reset; caught on first clock after
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            strap_done_reg <= 1'b0;
            rom_config_reg <= REG_RESET;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            rom_config_reg <= REG_RESET;
            rom_config_reg[BIT_ROM_WIDTH] <= ROM_WIDTH_STRAP;
            rom_config_reg[BIT_ROM_BUS]   <= ROM_BUS_STRAP;
        end else if (data_wr && index_reg == IDX_ROM_CONFIG) begin
            rom_config_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            IO_RDATA <= REG_RESET;
        end else if (data_rd) begin
            unique case (index_reg)
                IDX_R1_BASE:    IO_RDATA <= r1_base_reg;
                IDX_R1_EN:      IO_RDATA <= r1_en_reg;
                IDX_R2_BASE:    IO_RDATA <= r2_base_reg;
                IDX_R2_EN:      IO_RDATA <= r2_en_reg;
                IDX_ROM_CONFIG: IO_RDATA <= rom_config_reg;
                default:        IO_RDATA <= REG_RESET;
            endcase
        end else if (IO_RD && IO_ADDR == IDX_PORT) begin
            IO_RDATA <= index_reg;
        end
    end

    // One matcher per programmed region
    logic [7:0]  region_base [2];
    logic [7:0]  region_en   [2];
    logic [1:0]  region_hit;

    assign region_base[0] = r1_base_reg;
    assign region_base[1] = r2_base_reg;
    assign region_en[0]   = r1_en_reg;
    assign region_en[1]   = r2_en_reg;
    assign hit1           = region_hit[0];
    assign hit2           = region_hit[1];

    for (genvar g = 0; g < 2; g++) begin : g_region
        mrd_region_match u_match (
            .base_size (region_base[g]),
            .sub_en    (region_en[g]),
            .addr      (MEM_ADDR),
            .hit       (region_hit[g])
        );
    end

    mrd_rom_wait u_wait (
        .wait_code   (rom_config_reg[1:0]),
        .wait_states (rom_waits)
    );

    // Combinational classification, registered below
    logic [7:0]  reg_sel;
    logic        pr_hit;
    logic        pr_local;
    logic        pr_uncached;
    logic        below_16m;
    logic        isa_alias_hi;
    logic        rom_range;
    logic        rom_hit;
    logic        seg_c, seg_e, seg_f;
    mrd_target_e tgt_next;
    logic        cache_next;

    // Region 1 wins when both overlap
    always_comb begin
        reg_sel      = hit1 ? r1_base_reg : r2_base_reg;
        pr_hit       = hit1 || hit2;
        pr_local     = reg_sel[BIT_TARGET];
        pr_uncached  = reg_sel[BIT_UNCACHED];
        below_16m    = (MEM_ADDR[31:24] == 8'h_00);
        isa_alias_hi = MEM_ADDR[31] && MEM_ADDR[29];
    end

    // 64 KB segments of the first megabyte
    always_comb begin
        seg_c = (MEM_ADDR[31:16] == {4'h_0, SEG_C0});
        seg_e = (MEM_ADDR[31:16] == {4'h_0, SEG_E0});
        seg_f = (MEM_ADDR[31:16] == {4'h_0, SEG_F0});
    end

    // C segment is split in halves at A15
    always_comb begin
        rom_range = seg_f
            || (seg_e && rom_config_reg[BIT_RANGE_HI:BIT_RANGE_LO]
                         == 2'b00)
            || (seg_c && MEM_ADDR[15] == 1'b0
                && rom_config_reg[BIT_RANGE_HI])
            || (seg_c && MEM_ADDR[15] == 1'b1
                && rom_config_reg[BIT_RANGE_HI:BIT_RANGE_LO]
                   == 2'b11);
        rom_hit = MEM_IS_CPU && rom_range && !SEG_REMAP;
    end

    // Region first, then upper alias, ROM, claims, ISA below 16 MB
    always_comb begin
        tgt_next   = MRD_TGT_DEFAULT;
        cache_next = 1'b1;
        if (pr_hit) begin
            tgt_next   = pr_local ? MRD_TGT_LOCAL
                                  : MRD_TGT_ISA;
            cache_next = !pr_uncached && !SEG_UNCACHED;
        end else if (isa_alias_hi) begin
            tgt_next   = MRD_TGT_ISA;
            cache_next = 1'b0;
        end else if (rom_hit) begin
            tgt_next   = MRD_TGT_ROM;
            cache_next = 1'b0;
        end else if (DRAM_CLAIM || SHADOW_CLAIM) begin
            tgt_next   = MRD_TGT_DEFAULT;
            cache_next = !SEG_UNCACHED;
        end else if (LOCAL_DEV_CLAIM) begin
            tgt_next   = MRD_TGT_LOCAL;
            cache_next = 1'b0;
        end else if (below_16m) begin
            tgt_next   = MRD_TGT_ISA;
            cache_next = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            TARGET    <= MRD_TGT_DEFAULT;
            CACHEABLE <= 1'b0;
        end else begin
            TARGET    <= MEM_REQ ? tgt_next : MRD_TGT_DEFAULT;
            CACHEABLE <= MEM_REQ && cache_next;
        end
    end

    // CPU cycles to a local device leave the bus to that device
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            DESELECT <= 1'b0;
        end else begin
            DESELECT <= MEM_REQ && MEM_IS_CPU
                        && tgt_next == MRD_TGT_LOCAL;
        end
    end

    // DMA and masters cannot drive the device, so we run the cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            LOCAL_CYCLE <= 1'b0;
        end else begin
            LOCAL_CYCLE <= MEM_REQ && !MEM_IS_CPU
                           && pr_hit && pr_local;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ROM_CHIP_SELECT_N <= 1'b1;
        end else begin
            ROM_CHIP_SELECT_N <= !(MEM_REQ
                                   && tgt_next == MRD_TGT_ROM);
        end
    end

    // Extra waits only on ROM cycles; others keep the normal count
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ROM_EXTRA_WAITS <= 2'd0;
        end else begin
            ROM_EXTRA_WAITS <= (tgt_next == MRD_TGT_ROM)
                               ? rom_waits : 2'd0;
        end
    end

    // Placement follows the config register, straps included
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ROM_ON_SD_BUS <= 1'b0;
            ROM_16BIT     <= 1'b0;
        end else begin
            ROM_ON_SD_BUS <= rom_config_reg[BIT_ROM_BUS];
            ROM_16BIT     <= rom_config_reg[BIT_ROM_WIDTH];
        end
    end

    // High regions alias onto the 24-bit space
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ISA_ADDR <= 24'h_00_0000;
        end else begin
            ISA_ADDR <= MEM_ADDR[23:0];
        end
    end

    // A 16-bit ROM drops SA0
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ISA_ADDR_FROM_SA1 <= 1'b0;
        end else begin
            ISA_ADDR_FROM_SA1 <= (tgt_next == MRD_TGT_ROM)
                                 && rom_config_reg[BIT_ROM_WIDTH];
        end
    end

    // An 8-bit ROM on the D bus sits on the next-to-top lane
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            DATA_ON_D23_16 <= 1'b0;
        end else begin
            DATA_ON_D23_16 <= (tgt_next == MRD_TGT_ROM)
                              && !rom_config_reg[BIT_ROM_BUS]
                              && !rom_config_reg[BIT_ROM_WIDTH];
        end
    end

    // No parity on ISA or ROM
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PARITY_CHECK_EN <= 1'b0;
        end else begin
            PARITY_CHECK_EN <= MEM_REQ && (DRAM_CLAIM || SHADOW_CLAIM)
                               && tgt_next == MRD_TGT_DEFAULT;
        end
    end
endmodule // mrd_decoder

// >>> mrd_decoder_bench.sv
`timescale 1ns/1ps
module mrd_decoder_bench;
    import mrd_pkg::*;
    logic CORE_CLK, RST, IO_WR, IO_RD, MEM_REQ, MEM_IS_CPU, DRAM_CLAIM;
    logic [7:0] IO_ADDR, IO_WDATA, IO_RDATA;
    logic [31:0] MEM_ADDR;
    logic ROM_WIDTH_STRAP, ROM_BUS_STRAP, SHADOW_CLAIM, SEG_REMAP;
    logic SEG_UNCACHED, LOCAL_DEV_CLAIM, CACHEABLE, DESELECT, LOCAL_CYCLE;
    logic ROM_CHIP_SELECT_N, ROM_ON_SD_BUS, ROM_16BIT, ISA_ADDR_FROM_SA1;
    logic DATA_ON_D23_16, PARITY_CHECK_EN;
    logic [1:0] ROM_EXTRA_WAITS;
    logic [23:0] ISA_ADDR;
    mrd_target_e TARGET;
    int err_total = 0;
    int cmp_count = 0;
    logic [1:0] ws_exp [4] = '{WS_FOR_00, WS_FOR_01, WS_FOR_10, WS_FOR_11};

    mrd_decoder dut (.*);
    mrd_mem_side far (.MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
                      .DRAM_CLAIM(DRAM_CLAIM));

    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CORE_CLK);
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WR = 1'b1;
        @(negedge CORE_CLK);
        IO_WR = 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        io_wr(IDX_PORT, idx);
        io_wr(DATA_PORT, d);
    endtask

    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
        io_wr(IDX_PORT, idx);
        @(negedge CORE_CLK);
        IO_ADDR = DATA_PORT;
        IO_RD = 1'b1;
        @(negedge CORE_CLK);
        IO_RD = 1'b0;
        @(negedge CORE_CLK);
        chk(IO_RDATA, exp);
    endtask

    // Decode answer lands one edge later; looked at on the next low phase
    task automatic dec(input logic [31:0] a, input logic cpu,
                       input mrd_target_e tgt, input logic csn);
        @(negedge CORE_CLK);
        MEM_ADDR = a;
        MEM_IS_CPU = cpu;
        MEM_REQ = 1'b1;
        @(negedge CORE_CLK);
        chk(TARGET, tgt);
        chk(ROM_CHIP_SELECT_N, csn);
    endtask

    task automatic t_reset_values;
        reg_rd(IDX_R1_BASE, REG_RESET);
        reg_rd(IDX_R1_EN, REG_RESET);
        reg_rd(IDX_R2_BASE, REG_RESET);
        reg_rd(IDX_R2_EN, REG_RESET);
        reg_rd(IDX_ROM_CONFIG, 8'h80);
        reg_rd(8'h05, 8'h00);
    endtask

    task automatic t_default_map;
        dec(32'h000D_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b0);
        chk(PARITY_CHECK_EN, 1'b0);
        dec(32'h0005_0000, 1'b1, MRD_TGT_DEFAULT, 1'b1);
        chk(PARITY_CHECK_EN, 1'b1);
        SHADOW_CLAIM = 1'b1;
        dec(32'h000D_0000, 1'b1, MRD_TGT_DEFAULT, 1'b1);
        chk(CACHEABLE, 1'b1);
        SHADOW_CLAIM = 1'b0;
        LOCAL_DEV_CLAIM = 1'b1;
        dec(32'h000D_0000, 1'b1, MRD_TGT_LOCAL, 1'b1);
        chk(DESELECT, 1'b1);
        LOCAL_DEV_CLAIM = 1'b0;
        dec(32'hA012_3456, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(ISA_ADDR, 24'h12_3456);
        chk(CACHEABLE, 1'b0);
        dec(32'h000F_0000, 1'b0, MRD_TGT_ISA, 1'b1);
    endtask

    task automatic t_rom_config;
        for (int w = 0; w < 4; w++) begin
            reg_wr(IDX_ROM_CONFIG, 8'h80 | 8'(w));
            dec(32'h000F_FFF0, 1'b1, MRD_TGT_ROM, 1'b0);
            chk(ROM_EXTRA_WAITS, ws_exp[w]);
            chk(ROM_16BIT, 1'b1);
            chk(ISA_ADDR_FROM_SA1, 1'b1);
            chk(ROM_ON_SD_BUS, 1'b0);
            chk(DATA_ON_D23_16, 1'b0);
        end
        reg_wr(IDX_ROM_CONFIG, 8'h80);
        dec(32'h000E_0000, 1'b1, MRD_TGT_ROM, 1'b0);
        dec(32'h000C_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        reg_wr(IDX_ROM_CONFIG, 8'hA0);
        dec(32'h000C_7FFF, 1'b1, MRD_TGT_ROM, 1'b0);
        dec(32'h000C_8000, 1'b1, MRD_TGT_ISA, 1'b1);
        dec(32'h000E_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        reg_wr(IDX_ROM_CONFIG, 8'hB0);
        dec(32'h000C_8000, 1'b1, MRD_TGT_ROM, 1'b0);
        reg_wr(IDX_ROM_CONFIG, 8'hC0);
        dec(32'h000F_0000, 1'b1, MRD_TGT_ROM, 1'b0);
        chk(ROM_ON_SD_BUS, 1'b1);
        reg_wr(IDX_ROM_CONFIG, 8'h00);
        dec(32'h000F_0000, 1'b1, MRD_TGT_ROM, 1'b0);
        chk(DATA_ON_D23_16, 1'b1);
        chk(ISA_ADDR_FROM_SA1, 1'b0);
        chk(ROM_16BIT, 1'b0);
        SEG_REMAP = 1'b1;
        dec(32'h000F_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        SEG_REMAP = 1'b0;
        reg_wr(IDX_ROM_CONFIG, 8'h80);
    endtask

    task automatic t_regions;
        reg_wr(IDX_R1_BASE, 8'h01);
        reg_wr(IDX_R1_EN, 8'h02);
        reg_rd(IDX_R1_EN, 8'h02);
        dec(32'h0009_FFFF, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b1);
        dec(32'h0008_FFFF, 1'b1, MRD_TGT_DEFAULT, 1'b1);
        dec(32'h000A_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b0);
        SEG_UNCACHED = 1'b1;
        dec(32'h0009_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b0);
        SEG_UNCACHED = 1'b0;
        reg_wr(IDX_R1_BASE, 8'h41);
        dec(32'h0009_0000, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b0);
        reg_wr(IDX_R2_BASE, 8'hA2);
        reg_wr(IDX_R2_EN, 8'h80);
        dec(32'h0170_0000, 1'b1, MRD_TGT_LOCAL, 1'b1);
        chk(DESELECT, 1'b1);
        dec(32'h0170_0000, 1'b0, MRD_TGT_LOCAL, 1'b1);
        chk(LOCAL_CYCLE, 1'b1);
        dec(32'h016F_FFFF, 1'b1, MRD_TGT_DEFAULT, 1'b1);
        chk(DESELECT, 1'b0);
        reg_wr(IDX_R2_BASE, 8'h22);
        dec(32'h017F_FFFF, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(ISA_ADDR, 24'h7F_FFFF);
        reg_wr(IDX_R2_BASE, 8'h7C);
        reg_wr(IDX_R2_EN, 8'h01);
        dec(32'h000F_07FF, 1'b1, MRD_TGT_ISA, 1'b1);
        chk(CACHEABLE, 1'b0);
        dec(32'h000F_0800, 1'b1, MRD_TGT_ROM, 1'b0);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {RST, IO_WR, IO_RD, MEM_REQ, MEM_IS_CPU} = 5'b1_0000;
        {IO_ADDR, IO_WDATA, MEM_ADDR} = '0;
        {ROM_WIDTH_STRAP, ROM_BUS_STRAP} = 2'b10;
        {SHADOW_CLAIM, SEG_REMAP, SEG_UNCACHED, LOCAL_DEV_CLAIM} = 4'b0;
        repeat (4) @(negedge CORE_CLK);
        RST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        t_reset_values();
        t_default_map();
        t_rom_config();
        t_regions();
        tally_and_finish();
    end

    // Whole run is under two hundred cycles; this is ample margin
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule // mrd_decoder_bench

// >>> mrd_decoder_monitor.sv
`timescale 1ns/1ps
module mrd_decoder_monitor
    import mrd_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        MEM_REQ,
    input wire logic        MEM_IS_CPU,
    input wire logic [31:0] MEM_ADDR,
    input wire mrd_pkg::mrd_target_e TARGET,
    input wire logic        CACHEABLE,
    input wire logic        DESELECT,
    input wire logic        LOCAL_CYCLE,
    input wire logic        ROM_CHIP_SELECT_N,
    input wire logic        ROM_16BIT,
    input wire logic [1:0]  ROM_EXTRA_WAITS,
    input wire logic [23:0] ISA_ADDR,
    input wire logic        ISA_ADDR_FROM_SA1,
    input wire logic        PARITY_CHECK_EN
);
    import mrd_pkg::*;

    logic [23:0] low_addr;
    assign low_addr = MEM_ADDR[23:0];
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Top 128K of the upper window is left out, though the decoder sends it to ISA as well
    sequence s_upper_cpu;
        MEM_REQ && MEM_IS_CPU && MEM_ADDR[31] && MEM_ADDR[29]
            && !(&MEM_ADDR[31:17]);
    endsequence
    sequence s_dma_req;
        MEM_REQ && !MEM_IS_CPU;
    endsequence
    a_rom_sel_target: assert property (
        !ROM_CHIP_SELECT_N == (TARGET == MRD_TGT_ROM))
        else $error("rom select and target disagree");
    a_deselect_cpu_local: assert property (
        DESELECT |-> TARGET == MRD_TGT_LOCAL && $past(MEM_IS_CPU))
        else $error("deselect without cpu local hit");
    a_local_cycle_dma: assert property (
        LOCAL_CYCLE |-> $past(MEM_REQ) && !$past(MEM_IS_CPU))
        else $error("local cycle without dma request");
    a_isa_addr_alias: assert property (
        MEM_REQ |=> ISA_ADDR == $past(low_addr))
        else $error("isa address not low 24 bits");
    a_upper_alias_uncached: assert property (
        s_upper_cpu |=> TARGET == MRD_TGT_ISA && !CACHEABLE)
        else $error("upper window not uncached isa");
    a_rom_dma_excluded: assert property (
        s_dma_req |=> ROM_CHIP_SELECT_N)
        else $error("rom select on dma access");
    a_no_parity_isa: assert property (
        TARGET inside {MRD_TGT_ISA, MRD_TGT_ROM} |-> !PARITY_CHECK_EN)
        else $error("parity enabled on isa access");
    a_rom_waits_added: assert property (
        !ROM_CHIP_SELECT_N |-> ROM_EXTRA_WAITS != 2'b00)
        else $error("rom access without extra waits");
    a_rom_lane_width: assert property (
        !ROM_CHIP_SELECT_N |-> ISA_ADDR_FROM_SA1 == ROM_16BIT)
        else $error("rom addressing disagrees with width");
endmodule // mrd_decoder_monitor

bind mrd_decoder mrd_decoder_monitor mon (.*);

// >>> mrd_mem_side.sv
`timescale 1ns/1ps
// Local DRAM below the 640K hole claims the access, as the rest
// of the chip would; everything else is left to the decoder.
module mrd_mem_side (
    input  wire logic        MEM_REQ,
    input  wire logic [31:0] MEM_ADDR,
    output logic             DRAM_CLAIM
);
    assign DRAM_CLAIM = MEM_REQ && MEM_ADDR < 32'h000A_0000;
endmodule // mrd_mem_side

// >>> mrd_pkg.sv
package mrd_pkg;
    localparam logic [7:0] IDX_PORT          = 8'h_EC;
    localparam logic [7:0] DATA_PORT         = 8'h_ED;
    localparam logic [7:0] IDX_ROM_CONFIG    = 8'h_0C;
    localparam logic [7:0] IDX_R1_BASE       = 8'h_20;
    localparam logic [7:0] IDX_R1_EN         = 8'h_21;
    localparam logic [7:0] IDX_R2_BASE       = 8'h_22;
    localparam logic [7:0] IDX_R2_EN         = 8'h_23;
    localparam logic [7:0] REG_RESET         = 8'h_00;
    localparam int         BIT_TARGET        = 7;
    localparam int         BIT_UNCACHED      = 6;
    localparam int         BIT_ROM_WIDTH     = 7;
    localparam int         BIT_ROM_BUS       = 6;
    localparam int         BIT_RANGE_HI      = 5;
    localparam int         BIT_RANGE_LO      = 4;
    localparam logic [1:0] SZ_8M_CODE        = 2'b10;
    localparam logic [1:0] SZ_16K_CODE       = 2'b11;
    localparam logic [3:0] ROM_WS_BASE       = 4'h_0;
    localparam logic [1:0] RWS_0 = 2'b00;
    localparam logic [1:0] RWS_1 = 2'b01;
    localparam logic [1:0] RWS_2 = 2'b10;
    localparam logic [1:0] RWS_3 = 2'b11;
    localparam logic [1:0] WS_FOR_00 = 2'd3;
    localparam logic [1:0] WS_FOR_01 = 2'd1;
    localparam logic [1:0] WS_FOR_10 = 2'd2;
    localparam logic [1:0] WS_FOR_11 = 2'd3;
    localparam logic [11:0] SEG_C0 = 12'h_00C;
    localparam logic [11:0] SEG_E0 = 12'h_00E;
    localparam logic [11:0] SEG_F0 = 12'h_00F;
    localparam logic [7:0]  ISA_TOP_MB = 8'h_01;
    localparam logic [4:0]  HI_128M    = 5'h_00;
    localparam logic [5:0]  LOW_1M_HI  = 6'h_00;
    localparam logic [1:0]  UPPER_C    = 2'b11;

    typedef enum logic [1:0] {
        MRD_TGT_DEFAULT = 2'b00,
        MRD_TGT_ISA     = 2'b01,
        MRD_TGT_LOCAL   = 2'b10,
        MRD_TGT_ROM     = 2'b11
    } mrd_target_e;
endpackage

// >>> mrd_region_match.sv
`timescale 1ns/1ps
module mrd_region_match
    import mrd_pkg::*;
(
    input  wire logic [7:0]  base_size,
    input  wire logic [7:0]  sub_en,
    input  wire logic [31:0] addr,
    output logic             hit
);
    logic       in_region;
    logic [2:0] sub_idx;

    always_comb begin
        in_region = 1'b0;
        sub_idx   = 3'd0;
        if (!base_size[5]) begin
            // 512 KB window, 64 KB slices, below 16 MB
            in_region = (addr[31:24] == 8'h_00)
                        && (addr[23:19] == base_size[4:0]);
            sub_idx   = addr[18:16];
        end else if (base_size[5:4] == SZ_8M_CODE) begin
            in_region = (addr[31:27] == HI_128M)
                        && (addr[26:23] == base_size[3:0]);
            sub_idx   = addr[22:20];
        end else begin
            in_region = (addr[31:20] == SEG_F0 - 12'h_00F)
                        && (addr[19:18] == UPPER_C)
                        && (addr[17:14] == base_size[3:0]);
            sub_idx   = addr[13:11];
        end
        hit = in_region && sub_en[sub_idx];
    end
endmodule // mrd_region_match

// >>> mrd_rom_wait.sv
`timescale 1ns/1ps
module mrd_rom_wait
    import mrd_pkg::*;
(
    input  wire logic [1:0] wait_code,
    output logic [1:0]      wait_states
);
    always_comb begin
        unique case (wait_code)
            RWS_0: wait_states = WS_FOR_00;
            RWS_1: wait_states = WS_FOR_01;
            RWS_2: wait_states = WS_FOR_10;
            RWS_3: wait_states = WS_FOR_11;
        endcase
    end
endmodule // mrd_rom_wait
